/* File: ibsm_pkg.sv */
// Purpose: constants shared by the batch request monitor block
// Assumes: 32-bit register bus, byte addresses, one word per register
// Notes:   request vector layout is the order in which inputs are packed
package ibsm_pkg;

  // bus geometry
  localparam int unsigned IBSM_ADDR_W  = 8;
  localparam int unsigned IBSM_DATA_W  = 32;
  localparam int unsigned IBSM_BE_W    = 4;

  // register byte offsets
  localparam logic [7:0]  IBSM_OFS_CLK    = 8'h00;  // clock_source_request_monitor
  localparam logic [7:0]  IBSM_OFS_CONV0  = 8'h04;  // converter0_request_monitor
  localparam logic [7:0]  IBSM_OFS_CONV1  = 8'h08;  // converter1_request_monitor
  localparam logic [7:0]  IBSM_OFS_DISP   = 8'h0C;  // display_converter2_request_monitor
  localparam logic [7:0]  IBSM_OFS_FRT    = 8'h10;  // freerun_timer_request_monitor
  localparam logic [7:0]  IBSM_OFS_ICU    = 8'h14;  // input_capture_request_monitor
  localparam logic [7:0]  IBSM_OFS_DMA    = 8'h18;  // dma_request_select
  localparam logic [7:0]  IBSM_OFS_STAT   = 8'h1C;  // event status, write one to clear
  localparam logic [7:0]  IBSM_OFS_MASK   = 8'h20;  // event mask

  // monitor field widths
  localparam int unsigned IBSM_CLK_W   = 6;
  localparam int unsigned IBSM_CONV_W  = 4;
  localparam int unsigned IBSM_DISP_W  = 5;
  localparam int unsigned IBSM_FRT_W   = 18;
  localparam int unsigned IBSM_ICU_W   = 12;
  localparam int unsigned IBSM_FRTF_W  = 6;   // one free-run timer unit field
  localparam int unsigned IBSM_ICUF_W  = 4;   // one input-capture unit field
  localparam int unsigned IBSM_DMA_W   = 3;   // one select bit per converter unit
  localparam int unsigned IBSM_EVT_W   = 6;   // one event per merged vector

  // clock source bit positions
  localparam int unsigned IBSM_BIT_RTC  = 5;
  localparam int unsigned IBSM_BIT_WC   = 4;
  localparam int unsigned IBSM_BIT_UPLL = 3;
  localparam int unsigned IBSM_BIT_MPLL = 2;
  localparam int unsigned IBSM_BIT_SOSC = 1;
  localparam int unsigned IBSM_BIT_MOSC = 0;
  localparam int unsigned IBSM_BIT_LCD  = 4;  // in the display/converter2 monitor

  // packed raw request vector layout
  localparam int unsigned IBSM_RAW_CLK   = 0;
  localparam int unsigned IBSM_RAW_CONV0 = 6;
  localparam int unsigned IBSM_RAW_CONV1 = 10;
  localparam int unsigned IBSM_RAW_CONV2 = 14;
  localparam int unsigned IBSM_RAW_LCD   = 18;
  localparam int unsigned IBSM_RAW_FRT   = 19;
  localparam int unsigned IBSM_RAW_ICU   = 37;
  localparam int unsigned IBSM_RAW_W     = 49;

  // event bit per merged vector (40 to 45)
  localparam int unsigned IBSM_EVT_CLK   = 0;
  localparam int unsigned IBSM_EVT_CONV0 = 1;
  localparam int unsigned IBSM_EVT_CONV1 = 2;
  localparam int unsigned IBSM_EVT_DISP  = 3;
  localparam int unsigned IBSM_EVT_FRT   = 4;
  localparam int unsigned IBSM_EVT_ICU   = 5;

  // reset values
  localparam logic [31:0] IBSM_ZERO_WORD = 32'h0000_0000;

endpackage : ibsm_pkg

/* File: ibsm_sync.sv */
// Purpose: two flip-flop synchroniser for a vector of request levels
// Assumes: each bit is an independent level; no bus coherency needed
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ps
module ibsm_sync
  #(parameter int unsigned WIDTH = 8)
  (
  // clock and reset
  input  wire logic             clk_sys_i,
  input  wire logic             reset_i,
  // levels in and out
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
  );

  // both stages held in one state word
  typedef struct packed {
    logic [WIDTH-1:0] meta;    // may go metastable
    logic [WIDTH-1:0] stable;  // safe to use
  } ibsm_sync_s;

  ibsm_sync_s st_ff;     // registered state
  ibsm_sync_s nxt_st;    // next state

  // shift the levels one stage per clock
  always_comb begin
    nxt_st        = st_ff;
    nxt_st.meta   = async_i;
    nxt_st.stable = st_ff.meta;
  end

  // register the state
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign sync_o = st_ff.stable;

endmodule : ibsm_sync

/* File: ibsm_tb.sv */
// Purpose: self-checking bench for the batch request monitor block
// Assumes: request levels held for several cycles before each readback
// Notes:   reference model keeps the raw request image and dma select
`timescale 1ns/1ps
module tb;
  import ibsm_pkg::*;

  // clock, reset and bus
  logic                   clk_sys_i;
  logic                   reset_i;
  logic [IBSM_ADDR_W-1:0] avs_address_i;
  logic                   avs_read_i;
  logic                   avs_write_i;
  logic [IBSM_DATA_W-1:0] avs_writedata_i;
  logic [IBSM_BE_W-1:0]   avs_byteenable_i;
  logic [IBSM_DATA_W-1:0] rdata;
  logic                   wait_req;
  logic                   irq_o;
  // packed image of every request input, layout as the package
  logic [IBSM_RAW_W-1:0]  raw;
  logic [2:0]             dma_m;      // model of the dma select register
  logic [31:0]            d;          // last read word
  int                     bad_count;
  int                     n_tests;

  // request inputs are wired straight from the raw image
  ibsm_top uut (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wait_req), .irq_o(irq_o),
    .realtime_clock_request_i(raw[5]), .watch_counter_request_i(raw[4]),
    .usb_pll_stable_request_i(raw[3]), .main_pll_stable_request_i(raw[2]),
    .sub_osc_stable_request_i(raw[1]), .main_osc_stable_request_i(raw[0]),
    .converter0_request_field_i(raw[9:6]), .converter1_request_field_i(raw[13:10]),
    .converter2_request_field_i(raw[17:14]), .display_controller_request_i(raw[18]),
    .timer_unit0_freerun_field_i(raw[24:19]), .timer_unit1_freerun_field_i(raw[30:25]),
    .timer_unit2_freerun_field_i(raw[36:31]), .timer_unit0_capture_field_i(raw[40:37]),
    .timer_unit1_capture_field_i(raw[44:41]), .timer_unit2_capture_field_i(raw[48:45])
  );

  // 125 MHz clock
  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end

  // verdict and end of run, reached from the main flow or a timeout
  task automatic end_sim;
    if (bad_count == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_sim

  // one comparison, counted
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  // one avalon access; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rdv);
    int n;
    @(posedge clk_sys_i);
    avs_address_i   <= a;
    avs_write_i     <= wr;
    avs_read_i      <= !wr;
    avs_writedata_i <= wd;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (wait_req !== 1'b0 && n < 50);
    rdv = rdata;
    // release only after the edge that completed the access
    avs_read_i  <= 1'b0;
    avs_write_i <= 1'b0;
    if (n >= 50) begin
      chk(32'h0000_0001, 32'h0000_0000, "bus access never completed");
      end_sim();
    end
  endtask : bus

  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0000_0000, d);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] unused;
    bus(1'b1, a, v, unused);
  endtask : wr

  // read every monitor and compare with the raw image and dma model
  task automatic check_all;
    rd(IBSM_OFS_CLK);   chk(d, {26'h0, raw[5:0]}, "clock mon");
    rd(IBSM_OFS_CONV0);
    chk(d, {28'h0, dma_m[0] ? 4'h0 : raw[9:6]}, "conv0 mon");
    rd(IBSM_OFS_CONV1);
    chk(d, {28'h0, dma_m[1] ? 4'h0 : raw[13:10]}, "conv1 mon");
    rd(IBSM_OFS_DISP);
    chk(d, {27'h0, raw[18], dma_m[2] ? 4'h0 : raw[17:14]}, "disp mon");
    rd(IBSM_OFS_FRT);
    chk(d, {14'h0, raw[36:31], raw[30:25], raw[24:19]}, "frt mon");
    rd(IBSM_OFS_ICU);   chk(d, {20'h0, raw[48:37]}, "icu mon");
  endtask : check_all

  // main sequence
  initial begin
    reset_i = 1'b1;
    avs_address_i = 8'h00;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_writedata_i = 32'h0000_0000;
    avs_byteenable_i = 4'hF;
    raw = '0;
    dma_m = 3'h0;
    bad_count = 0;
    n_tests = 0;
    void'($urandom(70656));
    repeat (3) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    chk({31'h0, irq_o}, 32'h0000_0000, "irq after reset");
    check_all();
    rd(IBSM_OFS_STAT);  chk(d, 32'h0000_0000, "status reset");
    rd(IBSM_OFS_MASK);  chk(d, 32'h0000_0000, "mask reset");
    // walking one across every request line, each bit alone
    for (int i = 0; i < IBSM_RAW_W; i++) begin
      @(posedge clk_sys_i);
      raw <= {48'h0000_0000_0000, 1'b1} << i;
      repeat (5) @(posedge clk_sys_i);
      check_all();
    end
    // random request images with random dma routing
    for (int k = 0; k < 20; k++) begin
      @(posedge clk_sys_i);
      raw <= IBSM_RAW_W'({$urandom, $urandom});
      dma_m = 3'($urandom);
      wr(IBSM_OFS_DMA, {29'h0, dma_m});
      repeat (5) @(posedge clk_sys_i);
      check_all();
      // writes to monitors and unmapped space change nothing
      wr(IBSM_OFS_CLK, 32'hFFFF_FFFF);
      wr(IBSM_OFS_FRT, 32'hFFFF_FFFF);
      wr(8'h24, 32'hFFFF_FFFF);
      check_all();
      rd(8'h24);  chk(d, 32'h0000_0000, "unmapped read");
    end
    // write with lane 0 disabled is ignored
    avs_byteenable_i <= 4'h0;
    wr(IBSM_OFS_DMA, {29'h0, ~dma_m});
    avs_byteenable_i <= 4'hF;
    rd(IBSM_OFS_DMA);  chk(d, {29'h0, dma_m}, "dma after be0");
    // interrupt: quiet all requests, clear status, then raise the clock and capture requests
    @(posedge clk_sys_i);
    raw <= '0;
    dma_m = 3'h0;
    wr(IBSM_OFS_DMA, 32'h0000_0000);
    wr(IBSM_OFS_MASK, 32'h0000_0000);
    repeat (6) @(posedge clk_sys_i);
    wr(IBSM_OFS_STAT, 32'h0000_003F);
    rd(IBSM_OFS_STAT);  chk(d, 32'h0000_0000, "status cleared");
    raw[5] <= 1'b1;
    raw[40] <= 1'b1;
    repeat (8) @(posedge clk_sys_i);
    rd(IBSM_OFS_STAT);  chk(d, 32'h0000_0021, "status set");
    @(negedge clk_sys_i);
    chk({31'h0, irq_o}, 32'h0000_0000, "irq masked");
    wr(IBSM_OFS_MASK, 32'h0000_0001);
    @(negedge clk_sys_i);
    chk({31'h0, irq_o}, 32'h0000_0001, "irq unmasked");
    wr(IBSM_OFS_STAT, 32'h0000_0001);
    @(negedge clk_sys_i);
    chk({31'h0, irq_o}, 32'h0000_0000, "irq after clear");
    rd(IBSM_OFS_STAT);  chk(d, 32'h0000_0020, "status partly cleared");
    wr(IBSM_OFS_MASK, 32'h0000_0020);
    @(negedge clk_sys_i);
    chk({31'h0, irq_o}, 32'h0000_0001, "irq capture event");
    // reading a monitor leaves the requests and status untouched
    check_all();
    rd(IBSM_OFS_STAT);  chk(d, 32'h0000_0020, "status after reads");
    end_sim();
  end

endmodule : tb

/* File: ibsm_top.sv */
// Purpose: batch monitor of interrupt requests merged onto vectors 40 to 45
// Assumes: Avalon-MM slave with waitrequest, byte address, 125 MHz clock
// Notes:   request levels are synchronised, then sampled into monitors
//
// Notes on behaviour
// - clock monitor is vector 40, bits 31:6 zero
// - bit 5 shows real-time clock request
// - bit 4 shows watch counter request
// - bit 3 shows usb pll stable request
// - bit 2 shows main pll stable request
// - bit 1 shows sub oscillator stable request
// - bit 0 shows main oscillator stable request
// - converter0 monitor shows unit 0, vector 41
// - converter1 monitor shows unit 1, vector 42
// - converter bits: compare, overrun, scan, priority
// - dma-routed converter reads zero in monitor
// - reserved bits always read zero
// - display monitor bit 4 shows lcd request
// - display monitor bits 3:0 show converter 2
// - free-run monitor holds three 6-bit unit fields
// - field upper three zero, lower three peak
// - capture monitor holds three 4-bit unit fields
// - field bit n is capture channel n
//
// Implementation choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
module ibsm_top
  import ibsm_pkg::*;
  (
  // clock and reset
  input  wire logic                   clk_sys_i,
  input  wire logic                   reset_i,
  // avalon-mm slave
  input  wire logic [IBSM_ADDR_W-1:0] avs_address_i,
  input  wire logic                   avs_read_i,
  input  wire logic                   avs_write_i,
  input  wire logic [IBSM_DATA_W-1:0] avs_writedata_i,
  input  wire logic [IBSM_BE_W-1:0]   avs_byteenable_i,
  output logic      [IBSM_DATA_W-1:0] avs_readdata_o,
  output logic                        avs_waitrequest_o,
  // interrupt output
  output logic                        irq_o,
  // clock source requests
  input  wire logic                   realtime_clock_request_i,
  input  wire logic                   watch_counter_request_i,
  input  wire logic                   usb_pll_stable_request_i,
  input  wire logic                   main_pll_stable_request_i,
  input  wire logic                   sub_osc_stable_request_i,
  input  wire logic                   main_osc_stable_request_i,
  // converter and display requests
  input  wire logic [IBSM_CONV_W-1:0] converter0_request_field_i,
  input  wire logic [IBSM_CONV_W-1:0] converter1_request_field_i,
  input  wire logic [IBSM_CONV_W-1:0] converter2_request_field_i,
  input  wire logic                   display_controller_request_i,
  // free-run timer requests, per unit {zero ch2..0, peak ch2..0}
  input  wire logic [IBSM_FRTF_W-1:0] timer_unit0_freerun_field_i,
  input  wire logic [IBSM_FRTF_W-1:0] timer_unit1_freerun_field_i,
  input  wire logic [IBSM_FRTF_W-1:0] timer_unit2_freerun_field_i,
  // input capture requests, per unit channel 3..0
  input  wire logic [IBSM_ICUF_W-1:0] timer_unit0_capture_field_i,
  input  wire logic [IBSM_ICUF_W-1:0] timer_unit1_capture_field_i,
  input  wire logic [IBSM_ICUF_W-1:0] timer_unit2_capture_field_i
  );

  // whole block state in one word
  typedef struct packed {
    logic                   busy;       // waitrequest level, high when idle
    logic [IBSM_DATA_W-1:0] rdata;      // read data returned to master
    logic [IBSM_CLK_W-1:0]  mon_clk;    // clock source monitor
    logic [IBSM_CONV_W-1:0] mon_conv0;  // converter unit 0 monitor
    logic [IBSM_CONV_W-1:0] mon_conv1;  // converter unit 1 monitor
    logic [IBSM_DISP_W-1:0] mon_disp;   // lcd plus converter unit 2
    logic [IBSM_FRT_W-1:0]  mon_frt;    // free-run timer monitor
    logic [IBSM_ICU_W-1:0]  mon_icu;    // input capture monitor
    logic [IBSM_EVT_W-1:0]  vec_prev;   // merged vector levels, last cycle
    logic [IBSM_DMA_W-1:0]  dma_sel;    // converter routed to dma
    logic [IBSM_EVT_W-1:0]  evt_status; // sticky vector rise events
    logic [IBSM_EVT_W-1:0]  evt_mask;   // event enables
    logic                   irq;        // registered interrupt level
  } ibsm_state_s;

  ibsm_state_s             st_ff;      // registered state
  ibsm_state_s             nxt_st;     // next state
  logic [IBSM_RAW_W-1:0]   raw_req;    // packed request levels
  logic [IBSM_RAW_W-1:0]   sync_req;   // same, after synchroniser
  logic                    bus_req;    // any request on the bus
  logic                    bus_accept; // first cycle of a request
  logic                    bus_done;   // completing edge of a request
  logic                    wr_lane0;   // write reaching the low byte
  logic [IBSM_EVT_W-1:0]   vec_now;    // merged vector levels now
  logic [IBSM_EVT_W-1:0]   vec_rise;   // vector level went high
  logic [IBSM_EVT_W-1:0]   evt_clear;  // write-one-to-clear bits
  logic [IBSM_DATA_W-1:0]  rd_mux;     // read data selected by address

  // pack every request line in a fixed order
  assign raw_req = {timer_unit2_capture_field_i,
                    timer_unit1_capture_field_i,
                    timer_unit0_capture_field_i,
                    timer_unit2_freerun_field_i,
                    timer_unit1_freerun_field_i,
                    timer_unit0_freerun_field_i,
                    display_controller_request_i,
                    converter2_request_field_i,
                    converter1_request_field_i,
                    converter0_request_field_i,
                    realtime_clock_request_i,
                    watch_counter_request_i,
                    usb_pll_stable_request_i,
                    main_pll_stable_request_i,
                    sub_osc_stable_request_i,
                    main_osc_stable_request_i};

  // requests come from other blocks; synchronise before any use
  ibsm_sync #(
    .WIDTH     (IBSM_RAW_W)
  ) u_req_sync (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .async_i   (raw_req),
    .sync_o    (sync_req)
  );

  // read mux; anything not decoded reads as zero
  always_comb begin
    rd_mux = IBSM_ZERO_WORD;
    case (avs_address_i)
      IBSM_OFS_CLK: begin
        rd_mux[IBSM_CLK_W-1:0] = st_ff.mon_clk;
      end
      IBSM_OFS_CONV0: begin
        rd_mux[IBSM_CONV_W-1:0] = st_ff.mon_conv0;
      end
      IBSM_OFS_CONV1: begin
        rd_mux[IBSM_CONV_W-1:0] = st_ff.mon_conv1;
      end
      IBSM_OFS_DISP: begin
        rd_mux[IBSM_DISP_W-1:0] = st_ff.mon_disp;
      end
      IBSM_OFS_FRT: begin
        rd_mux[IBSM_FRT_W-1:0] = st_ff.mon_frt;
      end
      IBSM_OFS_ICU: begin
        rd_mux[IBSM_ICU_W-1:0] = st_ff.mon_icu;
      end
      IBSM_OFS_DMA: begin
        rd_mux[IBSM_DMA_W-1:0] = st_ff.dma_sel;
      end
      IBSM_OFS_STAT: begin
        rd_mux[IBSM_EVT_W-1:0] = st_ff.evt_status;
      end
      IBSM_OFS_MASK: begin
        rd_mux[IBSM_EVT_W-1:0] = st_ff.evt_mask;
      end
      default: begin
        rd_mux = IBSM_ZERO_WORD;
      end
    endcase
  end

  // bus handshake terms
  assign bus_req    = avs_read_i | avs_write_i;
  assign bus_accept = bus_req & st_ff.busy;
  assign bus_done   = bus_req & ~st_ff.busy;
  assign wr_lane0   = bus_done & avs_write_i & avs_byteenable_i[0];

  // merged vector levels, taken from the monitors themselves
  assign vec_now = {|st_ff.mon_icu, |st_ff.mon_frt, |st_ff.mon_disp,
                    |st_ff.mon_conv1, |st_ff.mon_conv0, |st_ff.mon_clk};
  assign vec_rise = vec_now & ~st_ff.vec_prev;

  // status clear only on the completing edge of a write
  assign evt_clear = (wr_lane0 && avs_address_i == IBSM_OFS_STAT) ?
                     avs_writedata_i[IBSM_EVT_W-1:0] : '0;

  // next state
  always_comb begin
    nxt_st = st_ff;
    // monitors follow the synchronised levels every cycle; reads never
    // touch the sources, so a read has no side effect on them
    nxt_st.mon_clk = sync_req[IBSM_RAW_CLK +: IBSM_CLK_W];
    // dma-routed units are forced to zero here, not at the source
    nxt_st.mon_conv0 = sync_req[IBSM_RAW_CONV0 +: IBSM_CONV_W]
                       & ~{IBSM_CONV_W{st_ff.dma_sel[0]}};
    nxt_st.mon_conv1 = sync_req[IBSM_RAW_CONV1 +: IBSM_CONV_W]
                       & ~{IBSM_CONV_W{st_ff.dma_sel[1]}};
    nxt_st.mon_disp[IBSM_CONV_W-1:0] = sync_req[IBSM_RAW_CONV2 +: IBSM_CONV_W]
                       & ~{IBSM_CONV_W{st_ff.dma_sel[2]}};
    nxt_st.mon_disp[IBSM_BIT_LCD] = sync_req[IBSM_RAW_LCD];
    nxt_st.mon_frt = sync_req[IBSM_RAW_FRT +: IBSM_FRT_W];
    nxt_st.mon_icu = sync_req[IBSM_RAW_ICU +: IBSM_ICU_W];
    nxt_st.vec_prev = vec_now;
    // one wait cycle per access, then waitrequest low for one edge
    if (bus_accept) begin
      nxt_st.busy = 1'b0;
      if (avs_read_i) begin
        nxt_st.rdata = rd_mux;
      end else begin
        nxt_st.rdata = IBSM_ZERO_WORD;
      end
    end else if (bus_done) begin
      nxt_st.busy = 1'b1;
    end
    // writes act only on control registers; monitor writes dropped
    if (wr_lane0) begin
      case (avs_address_i)
        IBSM_OFS_DMA: begin
          nxt_st.dma_sel = avs_writedata_i[IBSM_DMA_W-1:0];
        end
        IBSM_OFS_MASK: begin
          nxt_st.evt_mask = avs_writedata_i[IBSM_EVT_W-1:0];
        end
        default: begin
          nxt_st.dma_sel = st_ff.dma_sel;
        end
      endcase
    end
    // a rise in the clearing cycle survives: set beats clear
    nxt_st.evt_status = (st_ff.evt_status & ~evt_clear) | vec_rise;
    nxt_st.irq = |(nxt_st.evt_status & nxt_st.evt_mask);
  end

  // register the state; waitrequest idles high
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      st_ff      <= '0;
      st_ff.busy <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from flops
  assign avs_readdata_o    = st_ff.rdata;
  assign avs_waitrequest_o = st_ff.busy;
  assign irq_o             = st_ff.irq;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------

  // edges since reset release, saturating at the pipeline depth
  logic [1:0] age_ff;     // helper for the checks only

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      age_ff <= 2'h0;
    end else if (age_ff != 2'h3) begin
      age_ff <= age_ff + 2'h1;
    end
  end

  default clocking ibsm_cb @(posedge clk_sys_i);
  endclocking
  default disable iff (reset_i);

  // clock source monitor is the request lines three edges back
  AST_CLK_MIRROR: assert property (
    (age_ff == 2'h3) |-> (st_ff.mon_clk == {$past(realtime_clock_request_i, 3),
      $past(watch_counter_request_i, 3), $past(usb_pll_stable_request_i, 3),
      $past(main_pll_stable_request_i, 3), $past(sub_osc_stable_request_i, 3),
      $past(main_osc_stable_request_i, 3)}))
    else $error("clock source monitor does not follow its requests");

  // clock monitor read returns zero above bit 5
  AST_CLK_READ: assert property (
    (bus_accept && avs_read_i && avs_address_i == IBSM_OFS_CLK)
    |=> (avs_readdata_o == {26'h000_0000, $past(st_ff.mon_clk)}) && !avs_waitrequest_o)
    else $error("clock monitor read data wrong");

  // converter 0 monitor gated by its dma select
  AST_CONV0_DMA: assert property (
    (age_ff == 2'h3) |-> (st_ff.mon_conv0 ==
      ($past(converter0_request_field_i, 3) & ~{IBSM_CONV_W{$past(st_ff.dma_sel[0])}})))
    else $error("converter 0 monitor ignores dma routing");

  // converter 1 monitor read keeps reserved bits zero
  AST_CONV1_READ: assert property (
    (bus_accept && avs_read_i && avs_address_i == IBSM_OFS_CONV1)
    |=> (avs_readdata_o[31:4] == 28'h000_0000))
    else $error("converter 1 monitor reserved bits not zero");

  // lcd bit and converter 2 bits
  AST_DISP_MIRROR: assert property (
    (age_ff == 2'h3) |-> (st_ff.mon_disp == {$past(display_controller_request_i, 3),
      $past(converter2_request_field_i, 3) & ~{IBSM_CONV_W{$past(st_ff.dma_sel[2])}}}))
    else $error("display monitor does not follow its requests");

  // free-run fields in unit order 2, 1, 0
  AST_FRT_MIRROR: assert property (
    (age_ff == 2'h3) |-> (st_ff.mon_frt == {$past(timer_unit2_freerun_field_i, 3),
      $past(timer_unit1_freerun_field_i, 3), $past(timer_unit0_freerun_field_i, 3)}))
    else $error("free-run monitor field order wrong");

  // capture fields in unit order 2, 1, 0
  AST_ICU_MIRROR: assert property (
    (age_ff == 2'h3) |-> (st_ff.mon_icu == {$past(timer_unit2_capture_field_i, 3),
      $past(timer_unit1_capture_field_i, 3), $past(timer_unit0_capture_field_i, 3)}))
    else $error("capture monitor field order wrong");

  // a write anywhere but the control registers leaves them alone
  AST_MON_WRITE: assert property (
    (wr_lane0 && avs_address_i != IBSM_OFS_DMA && avs_address_i != IBSM_OFS_MASK)
    |=> $stable(st_ff.dma_sel) && $stable(st_ff.evt_mask))
    else $error("monitor write changed control state");

  // every access answers after exactly one wait cycle
  AST_ONE_WAIT: assert property (
    bus_accept |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
    else $error("waitrequest timing wrong");

  // an input capture vector rise is never lost to a same-cycle clear
  AST_SET_WINS: assert property (
    vec_rise[IBSM_EVT_ICU] |=> st_ff.evt_status[IBSM_EVT_ICU])
    else $error("event lost against clear");

  // converter 1 monitor gated by its dma select
  AST_CONV1_DMA: assert property (
    (age_ff == 2'h3) |-> (st_ff.mon_conv1 ==
      ($past(converter1_request_field_i, 3) & ~{IBSM_CONV_W{$past(st_ff.dma_sel[1])}})))
    else $error("converter 1 monitor ignores dma routing");

  // free-run monitor read keeps its reserved bits zero
  AST_FRT_READ: assert property (
    (bus_accept && avs_read_i && avs_address_i == IBSM_OFS_FRT)
    |=> (avs_readdata_o[IBSM_DATA_W-1:IBSM_FRT_W] == '0))
    else $error("free-run monitor reserved bits not zero");

  // capture monitor read keeps its reserved bits zero
  AST_ICU_READ: assert property (
    (bus_accept && avs_read_i && avs_address_i == IBSM_OFS_ICU)
    |=> (avs_readdata_o[IBSM_DATA_W-1:IBSM_ICU_W] == '0))
    else $error("capture monitor reserved bits not zero");

  // with no request on the bus waitrequest stays high
  AST_IDLE_WAIT: assert property (
    (!bus_req && st_ff.busy) |=> avs_waitrequest_o)
    else $error("waitrequest dropped without a request");

  // a clear with no new rise empties the status bit
  AST_STAT_CLEAR: assert property (
    (evt_clear[IBSM_EVT_CLK] && !vec_rise[IBSM_EVT_CLK])
    |=> !st_ff.evt_status[IBSM_EVT_CLK])
    else $error("status bit not cleared by write one");

  // main scenarios
  COV_CLK_READ:   cover property (bus_done && avs_read_i && avs_address_i == IBSM_OFS_CLK
                                  && avs_readdata_o != IBSM_ZERO_WORD);
  COV_DMA_FORCE:  cover property (st_ff.dma_sel[0] && |sync_req[IBSM_RAW_CONV0 +: IBSM_CONV_W]);
  COV_IRQ:        cover property ($rose(irq_o));
  COV_CLEAR_SET:  cover property (|(evt_clear & vec_rise));

endmodule : ibsm_top
